//--- core/pic_pkg.sv
// pic_pkg: constants for the pixel input capture block.
// assumes a 32-bit AXI4-Lite slave with word-aligned registers.
package pic_pkg;
  localparam int PIC_DATA_W = 24;
  localparam int PIC_HALF_W = 12;
  localparam int PIC_CFG_W = 8;
  localparam int PIC_ADDR_W = 8;
  localparam int PIC_SYNC_W = 31;
  // field positions in the sampled pin bundle
  localparam int PIC_SB_DATA = 0;
  localparam int PIC_SB_CTL = 24;
  localparam int PIC_SB_VS = 26;
  localparam int PIC_SB_HS = 27;
  localparam int PIC_SB_DE = 28;
  localparam int PIC_SB_CLKN = 29;
  localparam int PIC_SB_CLKP = 30;
  // data line fields
  localparam int PIC_CFG_LSB = 16;
  // register byte offsets
  localparam logic [7:0] PIC_OFS_CTRL = 8'h00;
  localparam logic [7:0] PIC_OFS_STATUS = 8'h04;
  localparam logic [7:0] PIC_OFS_PIXEL = 8'h08;
  // control register fields
  localparam int PIC_CTRL_W = 7;
  localparam int PIC_CB_BUS_WIDTH = 0;
  localparam int PIC_CB_DIFF_CLK = 1;
  localparam int PIC_CB_LOW_SWING = 2;
  localparam int PIC_CB_HOST_PORT = 3;
  localparam int PIC_CB_DESKEW = 4;
  localparam int PIC_CB_FIRST_UPPER = 5;
  localparam int PIC_CB_CTL3 = 6;
  localparam logic [6:0] PIC_CTRL_RESET = 7'h01;
  // status register fields
  localparam int PIC_STB_DIFF_ACT = 8;
  localparam int PIC_STB_HALF_PEND = 9;
  // bus responses
  localparam logic [1:0] PIC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PIC_RESP_SLVERR = 2'h2;
endpackage : pic_pkg

//--- core/pic_sync.sv
// pic_sync: two-flop synchroniser for a bundle of asynchronous levels.
// assumes each bit is a slow level; bits may skew by one cycle.
`timescale 1ns/1ns
module pic_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  always_comb begin
    meta_next = async_i;
    sync_next = meta_reg;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_o = sync_reg;
endmodule : pic_sync

//--- core/pic_capture.sv
// pic_capture: captures a parallel pixel bus on a sampled input clock.
// assumes the pixel clock is far slower than ref_clk_i (oversampled)
// and registers are reached over AXI4-Lite.
`timescale 1ns/1ns
// Function
// RULE1: wide mode: upper twelve lines form top half of each pixel word.
// RULE2: wide mode: lower twelve lines form bottom half, same single edge.
// RULE3: narrow mode: lower twelve lines carry half a pixel per each edge.
// RULE4: narrow mode: upper lines unused; lines 23..16 copied to config reg.
// RULE5: differential clock: phase crossover times data, flag and syncs.
// RULE6: differential clock only allowed with low swing setting.
// RULE7: single-ended: source drives positive input, negative held low.
// RULE8: active-video high: captured pixel word is sent for encoding.
// RULE9: active-video low: syncs and blanking bits are sent instead.
// RULE10: unused data inputs are tied to a fixed level by the system.
// RULE11: host port and deskew low: two inputs act as blanking bits 2..1.
// RULE12: narrow mode: two consecutive halves joined into one pixel word.
module pic_capture (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic pixel_clk_p_i,
  input wire logic pixel_clk_n_i,
  input wire logic [pic_pkg::PIC_DATA_W-1:0] data_i,
  input wire logic active_video_flag_i,
  input wire logic hsync_i,
  input wire logic vsync_i,
  input wire logic [2:1] blanking_control_bits_i,
  input wire logic [pic_pkg::PIC_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [pic_pkg::PIC_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [pic_pkg::PIC_DATA_W-1:0] pixel_data_o,
  output logic pixel_valid_o,
  output logic active_video_o,
  output logic hsync_o,
  output logic vsync_o,
  output logic [3:1] blanking_control_bits_o,
  output logic [pic_pkg::PIC_CFG_W-1:0] user_config_o
);
  import pic_pkg::*;

  logic [PIC_SYNC_W-1:0] pins_async;
  logic [PIC_SYNC_W-1:0] pins;
  logic [PIC_CTRL_W-1:0] ctrl_reg;
  logic [PIC_CTRL_W-1:0] ctrl_next;

  // capture state
  logic ref_prev_reg, ref_prev_next;
  logic half_pend_reg, half_pend_next;
  logic [PIC_HALF_W-1:0] half_reg, half_next;
  logic [4:0] ctl_hold_reg, ctl_hold_next;
  logic [PIC_DATA_W-1:0] pix_reg, pix_next;
  logic [PIC_DATA_W-1:0] last_pix_reg, last_pix_next;
  logic valid_reg, valid_next;
  logic de_reg, de_next;
  logic hs_reg, hs_next;
  logic vs_reg, vs_next;
  logic [3:1] ctl_reg, ctl_next;
  logic [PIC_CFG_W-1:0] cfg_reg, cfg_next;
  logic diff_act, ref_lvl, rise, fall, emit;
  logic [PIC_DATA_W-1:0] cap_pix;
  logic [4:0] cap_ctl, now_ctl;
  logic [2:1] ctl_in;

  // bus state
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;

  // every pin passes two flops; clock and data share the same delay
  assign pins_async = {pixel_clk_p_i, pixel_clk_n_i, active_video_flag_i,
    hsync_i, vsync_i, blanking_control_bits_i, data_i};

  pic_sync #(
    .WIDTH(PIC_SYNC_W)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(pins_async),
    .sync_o(pins)
  );

  always_comb begin
    // low swing gates the differential option
    diff_act = ctrl_reg[PIC_CB_DIFF_CLK] & ctrl_reg[PIC_CB_LOW_SWING]; // [RULE6]
    if (diff_act) begin
      ref_lvl = pins[PIC_SB_CLKP] & ~pins[PIC_SB_CLKN]; // [RULE5]
    end else begin
      ref_lvl = pins[PIC_SB_CLKP]; // [RULE7]
    end
    rise = ref_lvl & ~ref_prev_reg;
    fall = ~ref_lvl & ref_prev_reg;
    // multifunction inputs only mean blanking bits in this setting
    if (!ctrl_reg[PIC_CB_HOST_PORT] && !ctrl_reg[PIC_CB_DESKEW]) begin
      ctl_in = pins[PIC_SB_CTL+:2]; // [RULE11]
    end else begin
      ctl_in = 2'h0;
    end
    now_ctl = {pins[PIC_SB_DE], pins[PIC_SB_HS], pins[PIC_SB_VS], ctl_in};
    ref_prev_next = ref_lvl;
    half_pend_next = half_pend_reg;
    half_next = half_reg;
    ctl_hold_next = ctl_hold_reg;
    cfg_next = cfg_reg;
    emit = 1'b0;
    cap_pix = pix_reg;
    cap_ctl = ctl_hold_reg;
    if (ctrl_reg[PIC_CB_BUS_WIDTH]) begin
      half_pend_next = 1'b0;
      if (rise) begin
        emit = 1'b1;
        cap_pix[PIC_DATA_W-1:PIC_HALF_W] =
          pins[PIC_SB_DATA+PIC_HALF_W+:PIC_HALF_W]; // [RULE1]
        cap_pix[PIC_HALF_W-1:0] = pins[PIC_SB_DATA+:PIC_HALF_W]; // [RULE2]
        cap_ctl = now_ctl; // [RULE5]
      end
    end else begin
      if (rise) begin
        half_next = pins[PIC_SB_DATA+:PIC_HALF_W]; // [RULE3]
        ctl_hold_next = now_ctl; // [RULE5]
        half_pend_next = 1'b1;
        // upper lines carry no pixel here, only strap data
        cfg_next = pins[PIC_SB_DATA+PIC_CFG_LSB+:PIC_CFG_W]; // [RULE4]
      end else if (fall && half_pend_reg) begin
        half_pend_next = 1'b0;
        emit = 1'b1;
        // a falling edge with no first half is dropped, not paired
        if (ctrl_reg[PIC_CB_FIRST_UPPER]) begin
          cap_pix = {half_reg, pins[PIC_SB_DATA+:PIC_HALF_W]}; // [RULE12]
        end else begin
          cap_pix = {pins[PIC_SB_DATA+:PIC_HALF_W], half_reg}; // [RULE12]
        end
      end
    end
    valid_next = emit;
    pix_next = pix_reg;
    last_pix_next = last_pix_reg;
    de_next = de_reg;
    hs_next = hs_reg;
    vs_next = vs_reg;
    ctl_next = ctl_reg;
    if (emit) begin
      de_next = cap_ctl[4];
      hs_next = cap_ctl[3];
      vs_next = cap_ctl[2];
      last_pix_next = cap_pix;
      if (cap_ctl[4]) begin
        pix_next = cap_pix; // [RULE8]
        ctl_next = 3'h0;
      end else begin
        pix_next = '0;
        ctl_next = {ctrl_reg[PIC_CB_CTL3], cap_ctl[1:0]}; // [RULE9]
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ref_prev_reg <= 1'b0;
      half_pend_reg <= 1'b0;
      half_reg <= '0;
      ctl_hold_reg <= '0;
      pix_reg <= '0;
      last_pix_reg <= '0;
      valid_reg <= 1'b0;
      de_reg <= 1'b0;
      hs_reg <= 1'b0;
      vs_reg <= 1'b0;
      ctl_reg <= 3'h0;
      cfg_reg <= '0;
    end else begin
      ref_prev_reg <= ref_prev_next;
      half_pend_reg <= half_pend_next;
      half_reg <= half_next;
      ctl_hold_reg <= ctl_hold_next;
      pix_reg <= pix_next;
      last_pix_reg <= last_pix_next;
      valid_reg <= valid_next;
      de_reg <= de_next;
      hs_reg <= hs_next;
      vs_reg <= vs_next;
      ctl_reg <= ctl_next;
      cfg_reg <= cfg_next;
    end
  end

  // bus slave: address and data are taken together, one edge
  always_comb begin
    awready_next = 1'b0;
    wready_next = 1'b0;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    ctrl_next = ctrl_reg;
    if (bvalid_reg && s_axi_bready_i) begin
      bvalid_next = 1'b0;
    end
    if (awready_reg && s_axi_awvalid_i && s_axi_wvalid_i) begin
      bvalid_next = 1'b1;
      bresp_next = PIC_RESP_SLVERR;
      if (s_axi_awaddr_i == PIC_OFS_CTRL) begin
        bresp_next = PIC_RESP_OKAY;
        if (s_axi_wstrb_i[0]) begin
          ctrl_next = s_axi_wdata_i[PIC_CTRL_W-1:0];
        end
      end else if (s_axi_awaddr_i == PIC_OFS_STATUS ||
                   s_axi_awaddr_i == PIC_OFS_PIXEL) begin
        bresp_next = PIC_RESP_OKAY;
      end
    end else if (!awready_reg && !bvalid_reg &&
                 s_axi_awvalid_i && s_axi_wvalid_i) begin
      awready_next = 1'b1;
      wready_next = 1'b1;
    end
    arready_next = 1'b0;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (rvalid_reg && s_axi_rready_i) begin
      rvalid_next = 1'b0;
    end
    if (arready_reg && s_axi_arvalid_i) begin
      rvalid_next = 1'b1;
      rresp_next = PIC_RESP_OKAY;
      unique case (s_axi_araddr_i)
        PIC_OFS_CTRL: rdata_next = {25'h0, ctrl_reg};
        PIC_OFS_STATUS: rdata_next = {22'h0, half_pend_reg, diff_act,
          cfg_reg};
        PIC_OFS_PIXEL: rdata_next = {8'h0, last_pix_reg};
        default: begin
          rdata_next = 32'h0;
          rresp_next = PIC_RESP_SLVERR;
        end
      endcase
    end else if (!arready_reg && !rvalid_reg && s_axi_arvalid_i) begin
      arready_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= PIC_CTRL_RESET;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= PIC_RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= PIC_RESP_OKAY;
      rdata_reg <= 32'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o = wready_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign pixel_data_o = pix_reg;
  assign pixel_valid_o = valid_reg;
  assign active_video_o = de_reg;
  assign hsync_o = hs_reg;
  assign vsync_o = vs_reg;
  assign blanking_control_bits_o = ctl_reg;
  assign user_config_o = cfg_reg;
endmodule : pic_capture

//--- tb/pic_checker.sv
// pic_checker: port-level checks of the pixel capture block.
// assumes it is bound to every pic_capture instance.
`timescale 1ns/1ns
module pic_checker (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic [pic_pkg::PIC_DATA_W-1:0] pixel_data_o,
  input wire logic pixel_valid_o,
  input wire logic active_video_o,
  input wire logic [3:1] blanking_control_bits_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // pixel clock period is far longer than eight reference cycles
  chk_valid_spacing: assert property (
    pixel_valid_o |=> !pixel_valid_o [*8])
    else $error("pixel valid pulses too close");
  chk_blank_pixel_zero: assert property (
    !active_video_o |-> pixel_data_o == 24'h000000)
    else $error("pixel word not zero in blanking");
  chk_active_ctl_zero: assert property (
    active_video_o |-> blanking_control_bits_o == 3'h0)
    else $error("blanking bits set in active video");
  chk_word_holds: assert property (
    !pixel_valid_o |-> $stable(pixel_data_o))
    else $error("pixel word moved without valid");
  chk_aw_answer: assert property (s_axi_awvalid_i && s_axi_wvalid_i
    && !s_axi_bvalid_o && !s_axi_awready_o |-> ##[1:2] s_axi_awready_o)
    else $error("write address not taken in time");
  chk_write_resp: assert property (s_axi_awready_o |=> s_axi_bvalid_o)
    else $error("write response late");
  chk_ar_answer: assert property (s_axi_arvalid_i && !s_axi_rvalid_o
    && !s_axi_arready_o |-> ##[1:2] s_axi_arready_o)
    else $error("read address not taken in time");
  chk_read_resp: assert property (s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read data late");
  cover property (pixel_valid_o && active_video_o);
  cover property (pixel_valid_o && !active_video_o);
  cover property (s_axi_bvalid_o && s_axi_bready_i);
endmodule : pic_checker
bind pic_capture pic_checker chk (.ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .pixel_data_o(pixel_data_o),
  .pixel_valid_o(pixel_valid_o), .active_video_o(active_video_o),
  .blanking_control_bits_o(blanking_control_bits_o));

//--- tb/pic_source.sv
// pic_source: graphics controller model driving the pixel pins.
// assumes the bench calls pix() once per pixel clock period.
`timescale 1ns/1ns
module pic_source (
  input wire logic ref_clk_i,
  input wire logic diff_i,
  output logic clk_p_o,
  output logic clk_n_o,
  output logic [23:0] data_o,
  output logic de_o,
  output logic hs_o,
  output logic vs_o,
  output logic [2:1] ctl_o
);
  // clock stands low between calls; negative phase grounded if single
  assign clk_n_o = diff_i ? ~clk_p_o : 1'h0;
  initial begin
    clk_p_o = 1'h0;
    data_o = 24'h000000;
    {de_o, hs_o, vs_o, ctl_o} = 5'h00;
  end
  // a: rising half, b: falling half; five edges either side of each
  // pixel clock edge keep data steady past the sync delay
  task automatic pix(input logic [23:0] a, input logic [23:0] b,
      input logic de, input logic hs, input logic vs, input logic [2:1] c);
    @(posedge ref_clk_i);
    data_o <= a;
    {de_o, hs_o, vs_o, ctl_o} <= {de, hs, vs, c};
    repeat (5) @(posedge ref_clk_i);
    clk_p_o <= 1'h1;
    repeat (5) @(posedge ref_clk_i);
    data_o <= b;
    repeat (5) @(posedge ref_clk_i);
    clk_p_o <= 1'h0;
    repeat (5) @(posedge ref_clk_i);
    data_o <= ~b; // hold over, old value must not linger
  endtask : pix
endmodule : pic_source

//--- tb/pic_capture_tb_top.sv
// pic_capture_tb_top: self-checking bench for the pixel capture block.
// assumes pic_source on the pixel pins and pic_checker bound.
`timescale 1ns/1ns
module pic_capture_tb_top;
  import pic_pkg::*;
  logic clk = 1'h0, rst_n = 1'h0, diff = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, cfg;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, clk_p, clk_n;
  logic de, hs, vs, pvalid, act, hso, vso;
  logic [23:0] data, pix;
  logic [2:1] ctl;
  logic [3:1] ctlo;
  int miscompares = 0, n_compared = 0;
  int n_valid = 0;
  logic [3:0] wstrb = 4'hF;
  pic_source src (.ref_clk_i(clk), .diff_i(diff), .clk_p_o(clk_p),
    .clk_n_o(clk_n), .data_o(data), .de_o(de), .hs_o(hs), .vs_o(vs),
    .ctl_o(ctl));
  pic_capture dut (.ref_clk_i(clk), .rst_n_i(rst_n),
    .pixel_clk_p_i(clk_p), .pixel_clk_n_i(clk_n), .data_i(data),
    .active_video_flag_i(de), .hsync_i(hs), .vsync_i(vs),
    .blanking_control_bits_i(ctl), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .pixel_data_o(pix), .pixel_valid_o(pvalid),
    .active_video_o(act), .hsync_o(hso), .vsync_o(vso),
    .blanking_control_bits_o(ctlo), .user_config_o(cfg));
  // counts every captured pixel so pairing and dropping can be judged
  always @(posedge clk) begin
    if (pvalid === 1'h1) n_valid <= n_valid + 1;
  end
  task automatic wrap_up;
    if (miscompares == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  task automatic timeout;
    miscompares++;
    wrap_up();
  endtask : timeout
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
      if (bvalid === 1'h1) break;
    end
    bready <= 1'h0;
    if (i == 40) timeout();
    check(bresp, PIC_RESP_OKAY);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    int i;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (arready === 1'h1) arvalid <= 1'h0;
      if (rvalid === 1'h1) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    if (i == 40) timeout();
  endtask : axi_rd
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(PIC_OFS_CTRL, d, r);
    check(d, {25'h0, PIC_CTRL_RESET});
    axi_wr(PIC_OFS_STATUS, 32'hFFFFFFFF);
    axi_rd(PIC_OFS_CTRL, d, r);
    check(d, {25'h0, PIC_CTRL_RESET});
    // byte lane 0 off: control must keep its value
    wstrb <= 4'hE;
    axi_wr(PIC_OFS_CTRL, 32'h00);
    wstrb <= 4'hF;
    axi_rd(PIC_OFS_CTRL, d, r);
    check(d, {25'h0, PIC_CTRL_RESET});
    axi_rd(8'h0C, d, r);
    check(d, 32'h0);
    check(r, PIC_RESP_SLVERR);
  endtask : t_regs
  task automatic t_wide;
    int v0;
    axi_wr(PIC_OFS_CTRL, 32'h41);
    v0 = n_valid;
    src.pix(24'hA5C3F1, 24'h5A3C0E, 1'h1, 1'h0, 1'h0, 2'h3);
    check(pix, 24'hA5C3F1);
    check({act, ctlo}, 4'h8);
    src.pix(24'h123456, 24'hEDCBA9, 1'h0, 1'h1, 1'h0, 2'h2);
    check(pix, 24'h0);
    check({hso, vso, ctlo}, 5'h16);
    check(n_valid - v0, 32'h2);
    axi_wr(PIC_OFS_CTRL, 32'h09);
    src.pix(24'h123456, 24'hEDCBA9, 1'h0, 1'h0, 1'h1, 2'h3);
    check({hso, vso, ctlo}, 5'h08);
  endtask : t_wide
  task automatic t_narrow;
    logic [31:0] d;
    logic [1:0] r;
    int v0;
    axi_wr(PIC_OFS_CTRL, 32'h20);
    v0 = n_valid;
    // lines 15..12 held low, unused in this mode
    src.pix(24'h5A0ABC, 24'hC30123, 1'h1, 1'h0, 1'h0, 2'h0);
    repeat (4) @(posedge clk);
    check(pix, 24'hABC123);
    check(n_valid - v0, 32'h1);
    check(cfg, 8'h5A);
    axi_wr(PIC_OFS_CTRL, 32'h00);
    src.pix(24'h960ABC, 24'hC30123, 1'h1, 1'h0, 1'h0, 2'h0);
    repeat (4) @(posedge clk);
    check(pix, 24'h123ABC);
    axi_rd(PIC_OFS_STATUS, d, r);
    check(d[7:0], 8'h96);
  endtask : t_narrow
  task automatic t_diff;
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(PIC_OFS_CTRL, 32'h07);
    diff <= 1'h1;
    src.pix(24'h3C96E1, 24'hC3691E, 1'h1, 1'h1, 1'h1, 2'h0);
    check({pix, hso, vso}, {24'h3C96E1, 2'h3});
    axi_rd(PIC_OFS_STATUS, d, r);
    check(d[PIC_STB_DIFF_ACT], 1'h1);
    axi_wr(PIC_OFS_CTRL, 32'h03);
    axi_rd(PIC_OFS_STATUS, d, r);
    check(d[PIC_STB_DIFF_ACT], 1'h0);
  endtask : t_diff
  initial begin
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    t_regs();
    t_wide();
    t_narrow();
    t_diff();
    wrap_up();
  end
endmodule : pic_capture_tb_top
